// ### rtl/wdcm_pkg.sv
package wdcm_pkg;
  // service register field layout
  localparam int          WIN_HI        = 7;
  localparam int          WIN_LO        = 6;
  localparam int          KEY_HI        = 5;
  localparam int          KEY_LO        = 1;
  localparam int          CMON_BIT      = 0;
  localparam logic [4:0]  KEY_PATTERN   = 5'h0c;
  localparam logic [1:0]  WIN_RESET     = 2'h3;
  localparam logic        CMON_RESET    = 1'b1;
  localparam logic [7:0]  SVC_ADDR      = 8'hc7;
  // window and hold limits in instruction cycles
  localparam int          LOWER_LIMIT   = 2048;
  localparam int          UPPER_8K      = 8192;
  localparam int          HOLD_MIN_TC   = 16;
  // instruction cycle = 10 clocks of 5 ns (50 ns)
  localparam int          TC_NS         = 50;
  localparam int          CLK_NS        = 5;
  localparam int          TC_CLKS       = TC_NS / CLK_NS;
  // clock monitor: reject if no oscillator edge for this long
  localparam int          CM_TIMEOUT_US = 100;
  localparam int          CM_CLKS       = CM_TIMEOUT_US * 1000 / CLK_NS;

  typedef enum logic [1:0] {
    WD_IDLE,
    WD_PULL,
    WD_HOLD,
    WD_WAITHI
  } wdcm_out_t;

  typedef struct packed {
    logic [1:0] win;
    logic       cmon;
    logic       loaded;
  } wdcm_cfg_t;
endpackage : wdcm_pkg

// ### rtl/wdcm_core.sv
`timescale 1ns/100ps
module wdcm_core
  import wdcm_pkg::*;
#(
  parameter int CM_LIMIT = CM_CLKS
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  input  wire logic       osc_in,
  input  wire logic       timeout_output_pin_in,
  output logic            timeout_output_pin_out,
  output logic            timeout_output_pin_oe
);

  localparam int PW = 17;
  localparam int CW = $clog2(CM_LIMIT + 1);

  wdcm_cfg_t       cfg, next_cfg;
  wdcm_out_t       ost, next_ost;
  logic [3:0]      pre, next_pre;
  logic [PW-1:0]   wcnt, next_wcnt;
  logic [5:0]      hcnt, next_hcnt;
  logic [CW-1:0]   ccnt, next_ccnt;
  logic            osc_q, next_osc_q;
  logic            tc_tick, svc_wr, key_ok, match_ok, early, expired, trig, cm_err;
  logic [PW-1:0]   upper;

  // instruction cycle enable divider
  assign tc_tick = (pre == 4'(TC_CLKS - 1));
  assign svc_wr  = wr_en && (addr == SVC_ADDR);
  assign key_ok  = (wdata[KEY_HI:KEY_LO] == KEY_PATTERN);
  assign match_ok = key_ok && (wdata[WIN_HI:WIN_LO] == cfg.win)
                 && (wdata[CMON_BIT] == cfg.cmon);
  assign early   = (wcnt < PW'(LOWER_LIMIT));
  assign upper   = PW'(UPPER_8K) << cfg.win;
  assign expired = (wcnt >= upper);
  assign cm_err  = cfg.cmon && (ccnt >= CW'(CM_LIMIT));

  // service decode and trigger
  always_comb begin
    next_cfg = cfg;
    trig     = 1'b0;
    if (ost == WD_IDLE && svc_wr) begin
      if (!cfg.loaded) begin
        if (key_ok) begin
          next_cfg.win    = wdata[WIN_HI:WIN_LO];
          next_cfg.cmon   = wdata[CMON_BIT];
          next_cfg.loaded = 1'b1;
        end else begin
          trig = 1'b1;
        end
      end else if (!match_ok || early) begin
        trig = 1'b1;
      end
    end
    if (ost == WD_IDLE && expired) begin
      trig = 1'b1;
    end
  end

  // window counter, output sequencer, clock monitor
  always_comb begin
    next_pre   = tc_tick ? 4'h0 : pre + 4'h1;
    next_wcnt  = wcnt;
    next_ost   = ost;
    next_hcnt  = hcnt;
    next_osc_q = osc_in;
    next_ccnt  = (osc_in != osc_q) ? '0 : ((ccnt >= CW'(CM_LIMIT)) ? ccnt : ccnt + CW'(1));
    if (ost == WD_IDLE && svc_wr && !trig) begin
      next_wcnt = '0;
    end else if (ost == WD_IDLE && tc_tick && !expired) begin
      next_wcnt = wcnt + PW'(1);
    end
    unique case (ost)
      WD_IDLE: begin
        if (trig || cm_err || !timeout_output_pin_in) begin
          next_ost = WD_PULL;
        end
      end
      WD_PULL: begin
        next_hcnt = '0;
        if (!timeout_output_pin_in) begin
          next_ost = WD_HOLD;
        end
      end
      WD_HOLD: begin
        if (cm_err) begin
          next_hcnt = '0;
        end else if (tc_tick) begin
          next_hcnt = hcnt + 6'h1;
        end
        if (!cm_err && hcnt == 6'(HOLD_MIN_TC + 1)) begin
          next_ost = WD_WAITHI;
        end
      end
      WD_WAITHI: begin
        if (timeout_output_pin_in) begin
          next_ost  = WD_IDLE;
          next_wcnt = '0;
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg   <= '{win: WIN_RESET, cmon: CMON_RESET, loaded: 1'b0};
      ost   <= WD_IDLE;
      pre   <= '0;
      wcnt  <= '0;
      hcnt  <= '0;
      ccnt  <= '0;
      osc_q <= 1'b0;
    end else begin
      cfg   <= next_cfg;
      ost   <= next_ost;
      pre   <= next_pre;
      wcnt  <= next_wcnt;
      hcnt  <= next_hcnt;
      ccnt  <= next_ccnt;
      osc_q <= next_osc_q;
    end
  end

  // write-only register reads as zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else begin
      rdata <= 8'h00;
    end
  end

  // open-drain drive, low only while pulling or holding
  assign timeout_output_pin_out = 1'b0;
  assign timeout_output_pin_oe  = !reset && (ost == WD_PULL || ost == WD_HOLD);

  a_early_trip: assert property (@(posedge ref_clk) disable iff (reset)
    (ost == WD_IDLE && svc_wr && cfg.loaded && early) |=> ost == WD_PULL)
    else $error("early service did not trigger");
  a_bad_key: assert property (@(posedge ref_clk) disable iff (reset)
    (ost == WD_IDLE && svc_wr && !key_ok) |=> timeout_output_pin_oe)
    else $error("bad key did not trigger");
  a_cfg_frozen: assert property (@(posedge ref_clk) disable iff (reset)
    $past(cfg.loaded) |-> $stable(cfg.win) && $stable(cfg.cmon))
    else $error("settings changed after first write");
  a_ignore_busy: assert property (@(posedge ref_clk) disable iff (reset)
    (ost == WD_HOLD && svc_wr) |=> !(wcnt == '0 && $past(wcnt) != '0))
    else $error("service accepted while asserted");
  a_window_restart: assert property (@(posedge ref_clk) disable iff (reset)
    (ost == WD_IDLE && svc_wr && !cfg.loaded && key_ok) |=> wcnt == '0 && cfg.loaded)
    else $error("first write did not restart window");
  a_expire_trip: assert property (@(posedge ref_clk) disable iff (reset)
    (ost == WD_IDLE && expired) |=> ost == WD_PULL)
    else $error("expiry did not trigger");
  a_cm_drive: assert property (@(posedge ref_clk) disable iff (reset)
    (ost == WD_HOLD && cm_err) |=> ost == WD_HOLD)
    else $error("released during clock error");
  a_restart_hi: assert property (@(posedge ref_clk) disable iff (reset)
    (ost == WD_WAITHI && timeout_output_pin_in) |=> ost == WD_IDLE && wcnt == '0)
    else $error("window not restarted on high");

  // clocks spent holding the pin low with the clock healthy
  logic [15:0]     hold_clks, next_hold_clks;
  logic            rd_hit;

  // read strobe aimed at the service register
  assign rd_hit = rd_en && (addr == SVC_ADDR);

  // next value of the hold length counter
  always_comb begin
    next_hold_clks = hold_clks;
    if (ost != WD_HOLD || cm_err) begin
      next_hold_clks = '0;
    end else begin
      next_hold_clks = hold_clks + 16'h1;
    end
  end

  // hold length counter register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hold_clks <= '0;
    end else begin
      hold_clks <= next_hold_clks;
    end
  end

  // steps of a service and of a trip
  sequence s_svc_idle;
    ost == WD_IDLE && svc_wr;
  endsequence

  sequence s_first_load;
    s_svc_idle ##0 (!cfg.loaded && key_ok);
  endsequence

  sequence s_valid_svc;
    s_svc_idle ##0 (cfg.loaded && match_ok && !early && !expired && !cm_err && timeout_output_pin_in);
  endsequence

  sequence s_pin_seen_low;
    ost == WD_PULL && !timeout_output_pin_in;
  endsequence

  // first keyed write loads the written settings
  a_first_load: assert property (@(posedge ref_clk) disable iff (reset)
    s_first_load |=> cfg.win == $past(wdata[WIN_HI:WIN_LO]) && cfg.cmon == $past(wdata[CMON_BIT]))
    else $error("first write did not load settings");

  // a matching service inside the window restarts it
  a_valid_restart: assert property (@(posedge ref_clk) disable iff (reset)
    s_valid_svc |=> ost == WD_IDLE && wcnt == '0)
    else $error("valid service did not restart window");

  // pin seen low moves on to the hold phase
  a_pull_hold: assert property (@(posedge ref_clk) disable iff (reset)
    s_pin_seen_low |=> ost == WD_HOLD)
    else $error("hold not entered on low pin");

  // hold lasts at least the minimum instruction cycles
  a_hold_min: assert property (@(posedge ref_clk) disable iff (reset)
    (ost == WD_HOLD && next_ost == WD_WAITHI) |-> hold_clks >= 16'(HOLD_MIN_TC * TC_CLKS))
    else $error("hold released too early");

  // hold never exceeds twice the minimum
  a_hold_max: assert property (@(posedge ref_clk) disable iff (reset)
    (ost == WD_HOLD && next_ost == WD_WAITHI) |-> hold_clks <= 16'(2 * HOLD_MIN_TC * TC_CLKS))
    else $error("hold released too late");

  // the pin is only ever pulled low, never driven high
  a_drive_low: assert property (@(posedge ref_clk) disable iff (reset)
    timeout_output_pin_oe |-> !timeout_output_pin_out)
    else $error("pin driven high");

  // pin released while waiting for it to rise
  a_wait_release: assert property (@(posedge ref_clk) disable iff (reset)
    ost == WD_WAITHI |-> !timeout_output_pin_oe)
    else $error("pin still pulled after hold");

  // reset leaves idle defaults behind
  a_reset_defaults: assert property (@(posedge ref_clk)
    reset |=> cfg.win == WIN_RESET && cfg.cmon == CMON_RESET && !cfg.loaded && ost == WD_IDLE)
    else $error("reset defaults wrong");

  // pin low while idle starts a normal timeout
  a_powerup_low: assert property (@(posedge ref_clk) disable iff (reset)
    (ost == WD_IDLE && !timeout_output_pin_in) |=> ost == WD_PULL)
    else $error("low pin did not trip");

  // clock error while idle pulls the pin
  a_cm_trip: assert property (@(posedge ref_clk) disable iff (reset)
    (ost == WD_IDLE && cm_err) |=> ost == WD_PULL)
    else $error("clock error did not trip");

  // disabled monitor never reports an error
  a_cm_off: assert property (@(posedge ref_clk) disable iff (reset)
    !cfg.cmon |-> !cm_err)
    else $error("disabled monitor flagged error");

  // an oscillator edge clears the monitor error
  a_cm_quiet: assert property (@(posedge ref_clk) disable iff (reset)
    (osc_in != osc_q) |=> !cm_err)
    else $error("running clock flagged");

  // writes while busy leave the settings untouched
  a_busy_keep: assert property (@(posedge ref_clk) disable iff (reset)
    (ost != WD_IDLE && svc_wr) |=> $stable(cfg))
    else $error("settings changed while busy");

  // clock error during hold restarts the hold count
  a_hold_err: assert property (@(posedge ref_clk) disable iff (reset)
    (ost == WD_HOLD && cm_err) |=> hcnt == '0)
    else $error("hold count ran during clock error");

  // write-only register reads back as zero
  a_read_zero: assert property (@(posedge ref_clk) disable iff (reset)
    rd_hit |=> rdata == 8'h00)
    else $error("read data not zero");

endmodule : wdcm_core

// ### verif/test_watchdog_clock_monitor.sv
`timescale 1ns/100ps
module test_watchdog_clock_monitor;
  import wdcm_pkg::*;
  logic       ref_clk, reset, wr_en, rd_en, osc_in, osc_run, loaded, oe, pin_out, pin_hold;
  logic [7:0] addr, wdata, rdata, stored, rnd;
  int         cyc, t0, bad_count, total_checks;
  // pull-up on the shared pin: low while the block pulls it or pin_hold holds it low
  wire        pin_in = (oe || pin_hold) ? 1'b0 : 1'b1;
  wdcm_core #(.CM_LIMIT(50)) u_wdcm_core (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .osc_in(osc_in), .timeout_output_pin_in(pin_in),
    .timeout_output_pin_out(pin_out), .timeout_output_pin_oe(oe));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // oscillator stand-in, cycle counter and hang guard
  always @(posedge ref_clk) begin
    osc_in <= osc_run ? ~osc_in : osc_in;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] l);
    return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
  endfunction : lfsr
  task automatic check(input logic c, input string m);
    total_checks++;
    if (c !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : check
  task automatic wr(input logic [7:0] d);
    addr <= SVC_ADDR; wdata <= d; wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr
  // service write judged by the reference model
  task automatic svc(input logic [7:0] d);
    logic e;
    e = loaded ? (d !== stored || cyc - t0 < LOWER_LIMIT * TC_CLKS) : (d[KEY_HI:KEY_LO] !== KEY_PATTERN);
    wr(d);
    @(posedge ref_clk); #1;
    check(oe === e, "service outcome");
    if (!e) begin
      if (!loaded) stored = d;
      loaded = 1'b1;
      t0 = cyc;
    end
  endtask : svc
  // low time once the pin reads low must span 16 to 34 instruction cycles
  task automatic hold_chk();
    int n;
    n = 0;
    while (oe === 1'b1 && n < 2000) begin
      @(posedge ref_clk); #1;
      n++;
    end
    check(n >= HOLD_MIN_TC * TC_CLKS && n <= 34 * TC_CLKS, "hold length");
    t0 = cyc;
  endtask : hold_chk
  task automatic late();
    while (cyc - t0 < LOWER_LIMIT * TC_CLKS + 30) @(posedge ref_clk);
    #1;
  endtask : late
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    reset = 1'b1; addr = 8'h00; wdata = 8'h00; wr_en = 1'b0; rd_en = 1'b0;
    osc_in = 1'b0; osc_run = 1'b1; loaded = 1'b0; stored = 8'h00; rnd = 8'h49; cyc = 0; t0 = 0;
    pin_hold = 1'b0;
    bad_count = 0; total_checks = 0;
    repeat (12) @(posedge ref_clk);
    check(oe === 1'b0, "idle in reset");
    reset <= 1'b0;
    addr <= SVC_ADDR; rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    check(rdata === 8'h00, "read of write-only");
    @(posedge ref_clk);
    svc({2'h0, KEY_PATTERN, 1'b1});
    svc({2'h0, KEY_PATTERN, 1'b1});
    hold_chk();
    $display("test early service done");
    late();
    rnd = lfsr(rnd);
    if (rnd === stored) rnd = rnd ^ 8'h01;
    svc(rnd);
    wr(8'h00);
    hold_chk();
    $display("test bad service done");
    late();
    svc(stored);
    repeat (300) @(posedge ref_clk);
    check(oe === 1'b0, "running clock accepted");
    osc_run <= 1'b0;
    repeat (300) @(posedge ref_clk);
    #1;
    check(oe === 1'b1, "stopped clock flagged");
    osc_run <= 1'b1;
    hold_chk();
    $display("test clock monitor done");
    // second reset with the pin held low from outside
    reset <= 1'b1;
    pin_hold <= 1'b1;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    loaded = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check(oe === 1'b1, "low pin at start trips");
    pin_hold <= 1'b0;
    hold_chk();
    @(posedge ref_clk);
    svc({2'h1, KEY_PATTERN, 1'b0});
    osc_run <= 1'b0;
    repeat (300) @(posedge ref_clk);
    #1;
    check(oe === 1'b0, "monitor off ignores clock");
    osc_run <= 1'b1;
    $display("test restart and monitor off done");
    tally_and_finish();
  end
endmodule : test_watchdog_clock_monitor
